// >>> inc/mtseq_consts.vh
// constants for the measurement trigger sequencer
`ifndef MTSEQ_CONSTS_VH
`define MTSEQ_CONSTS_VH

// register byte offsets
`define MTS_OFF_CTRL      8'h00
`define MTS_OFF_CMD       8'h04
`define MTS_OFF_SAMPLES   8'h08
`define MTS_OFF_TRIGS     8'h0C
`define MTS_OFF_DELAY     8'h10
`define MTS_OFF_MEASCFG   8'h14
`define MTS_OFF_BAND      8'h18
`define MTS_OFF_STATUS    8'h1C
`define MTS_OFF_HELD      8'h20

// ctrl field positions
`define MTS_CTRL_SRC_LSB  0
`define MTS_CTRL_REMOTE   3
`define MTS_CTRL_HOLD     4
`define MTS_CTRL_DAUTO    5
// cmd bits
`define MTS_CMD_INIT      0
`define MTS_CMD_BUSTRIG   1
`define MTS_CMD_ABORT     2
// meas cfg field positions
`define MTS_CFG_FUNC_LSB  0
`define MTS_CFG_PLC       2
`define MTS_CFG_RNG_LSB   4
`define MTS_CFG_FILT_LSB  6

// trigger sources
`define MTS_SRC_AUTO      3'h0
`define MTS_SRC_IMM       3'h1
`define MTS_SRC_SINGLE    3'h2
`define MTS_SRC_EXT       3'h3
`define MTS_SRC_BUS       3'h4
// measurement functions
`define MTS_FN_DC         2'h0
`define MTS_FN_RES        2'h1
`define MTS_FN_AC         2'h2
`define MTS_FN_FREQ       2'h3

// reset values
`define MTS_RST_CTRL      6'h20
`define MTS_RST_SAMPLES   16'h0001
`define MTS_RST_TRIGS     16'h0001
`define MTS_RST_DELAY     32'h00000000
`define MTS_RST_MEASCFG   8'h00
`define MTS_RST_BAND      32'h00000000

// limits
`define MTS_MAX_SAMPLES   16'd50000
`define MTS_MAX_DELAY_S   3600
`define MTS_MAX_DELAY_US  32'd3600000000

// timebase
`define MTS_CLK_NS        50
`define MTS_TICK_NS       1000
`define MTS_TICK_CYC      (`MTS_TICK_NS / `MTS_CLK_NS)
`define MTS_COMP_NS       2000
`define MTS_COMP_CYC      (`MTS_COMP_NS / `MTS_CLK_NS)

// automatic delays in microseconds
`define MTS_D_0S_US       32'd0
`define MTS_D_1MS0_US     32'd1000
`define MTS_D_1MS5_US     32'd1500
`define MTS_D_10MS_US     32'd10000
`define MTS_D_15MS_US     32'd15000
`define MTS_D_100MS_US    32'd100000
`define MTS_D_200MS_US    32'd200000
`define MTS_D_600MS_US    32'd600000
`define MTS_D_1S0_US      32'd1000000
`define MTS_D_1S5_US      32'd1500000
`define MTS_D_7S0_US      32'd7000000

// axi responses
`define MTS_RESP_OKAY     2'h0
`define MTS_RESP_SLVERR   2'h2

`endif

// >>> logic/mtseq_top.v
// measurement trigger sequencer with axi4-lite register access
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "mtseq_consts.vh"

module mtseq_top (
    input  wire        MCLK_IN,
    input  wire        RST_N_IN,
    input  wire        AXI_AWVALID_IN,
    output wire        AXI_AWREADY_OUT,
    input  wire [7:0]  AXI_AWADDR_IN,
    input  wire        AXI_WVALID_IN,
    output wire        AXI_WREADY_OUT,
    input  wire [31:0] AXI_WDATA_IN,
    input  wire [3:0]  AXI_WSTRB_IN,
    output reg         AXI_BVALID_OUT,
    input  wire        AXI_BREADY_IN,
    output reg  [1:0]  AXI_BRESP_OUT,
    input  wire        AXI_ARVALID_IN,
    output wire        AXI_ARREADY_OUT,
    input  wire [7:0]  AXI_ARADDR_IN,
    output reg         AXI_RVALID_OUT,
    input  wire        AXI_RREADY_IN,
    output reg  [31:0] AXI_RDATA_OUT,
    output reg  [1:0]  AXI_RRESP_OUT,
    input  wire        SINGLE_KEY_IN,
    input  wire        EXTERNAL_TRIGGER_INPUT_IN,
    output reg         MEASUREMENT_COMPLETE_PULSE_N_OUT,
    output reg         TRIGGER_READY_INDICATOR_OUT,
    output reg         EXTERNAL_SOURCE_INDICATOR_OUT,
    output reg         SAMPLING_OUT,
    output reg         MEAS_START_OUT,
    input  wire        MEAS_DONE_IN,
    input  wire [31:0] READING_IN,
    output reg         BEEP_OUT
);

    localparam S_IDLE  = 3'd0;
    localparam S_WAIT  = 3'd1;
    localparam S_DELAY = 3'd2;
    localparam S_START = 3'd3;
    localparam S_BUSY  = 3'd4;

    localparam integer TICK_END  = `MTS_TICK_CYC - 1;
    localparam integer COMP_END  = `MTS_COMP_CYC - 1;
    localparam [4:0]   TICK_LAST = TICK_END[4:0];
    localparam [5:0]   COMP_LAST = COMP_END[5:0];

    reg  [5:0]  ctrl;
    reg  [15:0] samples;
    reg  [15:0] trigs;
    reg  [31:0] delay_us;
    reg  [7:0]  meas_cfg;
    reg  [31:0] band;
    reg  [31:0] held;
    reg         frozen;
    reg  [2:0]  state;
    reg  [15:0] samp_left;
    reg  [15:0] trigger_ready_indicator_left;
    reg  [31:0] delay_left;
    reg  [4:0]  tick_cnt;
    reg  [5:0]  comp_cnt;
    reg         ext_prev;
    reg         key_prev;
    reg  [31:0] last_reading;
    reg  [1:0]  stable_cnt;
    reg         have_last;
    reg         cmd_init;
    reg         cmd_bus;
    reg         cmd_abort;

    wire        wr_go = AXI_AWVALID_IN && AXI_WVALID_IN && !AXI_BVALID_OUT;
    wire        rd_go = AXI_ARVALID_IN && !AXI_RVALID_OUT;
    wire        remote = ctrl[`MTS_CTRL_REMOTE];
    wire [2:0]  src_raw = ctrl[`MTS_CTRL_SRC_LSB +: 3];
    // remote operation never runs free: auto falls back to immediate
    wire [2:0]  src = (remote && src_raw == `MTS_SRC_AUTO) ? `MTS_SRC_IMM : src_raw;
    wire        tick = (tick_cnt == TICK_LAST);
    wire        ext_edge = ext_prev && !EXTERNAL_TRIGGER_INPUT_IN;
    wire        key_edge = SINGLE_KEY_IN && !key_prev;
    wire [15:0] trigger_ready_indicator_total = (remote && trigs != 16'h0000) ? trigs : 16'h0001;
    wire [31:0] diff = READING_IN - last_reading;
    wire [31:0] abs_diff = diff[31] ? (32'h00000000 - diff) : diff;
    wire        in_band = have_last && (abs_diff <= band);
    reg         fire;
    reg  [31:0] rd_data;
    reg         rd_ok;

    assign AXI_AWREADY_OUT = wr_go;
    assign AXI_WREADY_OUT  = wr_go;
    assign AXI_ARREADY_OUT = !AXI_RVALID_OUT;

    // byte-lane merge for partial writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] new_val;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
    endfunction

    // automatic settling delay from the measurement setup
    function [31:0] auto_delay;
        input [1:0] fn;
        input       plc_ge1;
        input [1:0] rng;
        input [1:0] filt;
        input       front_auto;
        begin
            case (fn)
                `MTS_FN_DC:
                    auto_delay = plc_ge1 ? `MTS_D_1MS5_US : `MTS_D_1MS0_US;
                `MTS_FN_RES:
                    case (rng)
                        2'h0:    auto_delay = plc_ge1 ? `MTS_D_1MS5_US : `MTS_D_1MS0_US;
                        2'h1:    auto_delay = plc_ge1 ? `MTS_D_15MS_US : `MTS_D_10MS_US;
                        default: auto_delay = `MTS_D_100MS_US;
                    endcase
                `MTS_FN_AC:
                    case (filt)
                        2'h0:    auto_delay = front_auto ? `MTS_D_1S5_US : `MTS_D_7S0_US;
                        2'h1:    auto_delay = front_auto ? `MTS_D_200MS_US : `MTS_D_1S0_US;
                        default: auto_delay = front_auto ? `MTS_D_100MS_US : `MTS_D_600MS_US;
                    endcase
                default:
                    auto_delay = front_auto ? `MTS_D_0S_US : `MTS_D_1S0_US;
            endcase
        end
    endfunction

    wire [31:0] wr_ctrl   = merge({26'h0, ctrl}, AXI_WDATA_IN, AXI_WSTRB_IN);
    wire [31:0] wr_samp   = merge({16'h0, samples}, AXI_WDATA_IN, AXI_WSTRB_IN);
    wire [31:0] wr_trigs  = merge({16'h0, trigs}, AXI_WDATA_IN, AXI_WSTRB_IN);
    wire [31:0] wr_delay  = merge(delay_us, AXI_WDATA_IN, AXI_WSTRB_IN);
    wire [31:0] wr_cfg    = merge({24'h0, meas_cfg}, AXI_WDATA_IN, AXI_WSTRB_IN);
    wire [31:0] eff_delay = ctrl[`MTS_CTRL_DAUTO] ?
        auto_delay(meas_cfg[`MTS_CFG_FUNC_LSB +: 2], meas_cfg[`MTS_CFG_PLC],
                   meas_cfg[`MTS_CFG_RNG_LSB +: 2], meas_cfg[`MTS_CFG_FILT_LSB +: 2],
                   src == `MTS_SRC_AUTO) : delay_us;

    // trigger qualification per source
    always @*
    begin
        case (src)
            `MTS_SRC_AUTO:   fire = 1'b1;
            `MTS_SRC_IMM:    fire = 1'b1;
            `MTS_SRC_SINGLE: fire = key_edge;
            `MTS_SRC_EXT:    fire = ext_edge;
            `MTS_SRC_BUS:    fire = cmd_bus;
            default:         fire = 1'b0;
        endcase
    end

    // register file writes; all volatile, reset restores defaults
    always @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            ctrl           <= `MTS_RST_CTRL;
            samples        <= `MTS_RST_SAMPLES;
            trigs          <= `MTS_RST_TRIGS;
            delay_us       <= `MTS_RST_DELAY;
            meas_cfg       <= `MTS_RST_MEASCFG;
            band           <= `MTS_RST_BAND;
            cmd_init       <= 1'b0;
            cmd_bus        <= 1'b0;
            cmd_abort      <= 1'b0;
            AXI_BVALID_OUT <= 1'b0;
            AXI_BRESP_OUT  <= `MTS_RESP_OKAY;
        end
        else
        begin
            cmd_init  <= 1'b0;
            cmd_bus   <= 1'b0;
            cmd_abort <= 1'b0;
            if (AXI_BVALID_OUT && AXI_BREADY_IN)
                AXI_BVALID_OUT <= 1'b0;
            if (wr_go)
            begin
                AXI_BVALID_OUT <= 1'b1;
                AXI_BRESP_OUT  <= `MTS_RESP_OKAY;
                case (AXI_AWADDR_IN)
                    `MTS_OFF_CTRL:
                        ctrl <= wr_ctrl[5:0];
                    `MTS_OFF_CMD:
                    begin
                        if (AXI_WSTRB_IN[0])
                        begin
                            cmd_init  <= AXI_WDATA_IN[`MTS_CMD_INIT];
                            cmd_bus   <= AXI_WDATA_IN[`MTS_CMD_BUSTRIG];
                            cmd_abort <= AXI_WDATA_IN[`MTS_CMD_ABORT];
                        end
                    end
                    `MTS_OFF_SAMPLES:
                        // out-of-range counts clamp instead of erroring
                        if (wr_samp[15:0] == 16'h0000)
                            samples <= 16'h0001;
                        else if (wr_samp[15:0] > `MTS_MAX_SAMPLES)
                            samples <= `MTS_MAX_SAMPLES;
                        else
                            samples <= wr_samp[15:0];
                    `MTS_OFF_TRIGS:
                        trigs <= wr_trigs[15:0];
                    `MTS_OFF_DELAY:
                        delay_us <= (wr_delay > `MTS_MAX_DELAY_US) ?
                                    `MTS_MAX_DELAY_US : wr_delay;
                    `MTS_OFF_MEASCFG:
                        meas_cfg <= wr_cfg[7:0];
                    `MTS_OFF_BAND:
                        band <= merge(band, AXI_WDATA_IN, AXI_WSTRB_IN);
                    `MTS_OFF_STATUS, `MTS_OFF_HELD:
                        AXI_BRESP_OUT <= `MTS_RESP_OKAY;
                    default:
                        AXI_BRESP_OUT <= `MTS_RESP_SLVERR;
                endcase
            end
        end
    end

    // read decode
    always @*
    begin
        rd_ok = 1'b1;
        case (AXI_ARADDR_IN)
            `MTS_OFF_CTRL:    rd_data = {26'h0, ctrl};
            `MTS_OFF_CMD:     rd_data = 32'h00000000;
            `MTS_OFF_SAMPLES: rd_data = {16'h0, samples};
            `MTS_OFF_TRIGS:   rd_data = {16'h0, trigs};
            `MTS_OFF_DELAY:   rd_data = delay_us;
            `MTS_OFF_MEASCFG: rd_data = {24'h0, meas_cfg};
            `MTS_OFF_BAND:    rd_data = band;
            `MTS_OFF_STATUS:
                rd_data = {trigger_ready_indicator_left, 9'h0, frozen, EXTERNAL_SOURCE_INDICATOR_OUT,
                           TRIGGER_READY_INDICATOR_OUT, SAMPLING_OUT, state};
            `MTS_OFF_HELD:    rd_data = held;
            default:
            begin
                rd_data = 32'h00000000;
                rd_ok   = 1'b0;
            end
        endcase
    end

    always @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            AXI_RVALID_OUT <= 1'b0;
            AXI_RDATA_OUT  <= 32'h00000000;
            AXI_RRESP_OUT  <= `MTS_RESP_OKAY;
        end
        else if (rd_go)
        begin
            AXI_RVALID_OUT <= 1'b1;
            AXI_RDATA_OUT  <= rd_data;
            AXI_RRESP_OUT  <= rd_ok ? `MTS_RESP_OKAY : `MTS_RESP_SLVERR;
        end
        else if (AXI_RREADY_IN)
            AXI_RVALID_OUT <= 1'b0;
    end

    // trigger sequencer
    always @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            state          <= S_IDLE;
            samp_left      <= 16'h0000;
            trigger_ready_indicator_left      <= 16'h0000;
            delay_left     <= 32'h00000000;
            tick_cnt       <= 5'h00;
            MEAS_START_OUT <= 1'b0;
            ext_prev       <= 1'b1;
            key_prev       <= 1'b0;
        end
        else
        begin
            ext_prev       <= EXTERNAL_TRIGGER_INPUT_IN;
            key_prev       <= SINGLE_KEY_IN;
            MEAS_START_OUT <= 1'b0;
            tick_cnt       <= tick ? 5'h00 : tick_cnt + 5'h01;
            if (cmd_abort)
                state <= S_IDLE;
            else
            begin
                case (state)
                    S_IDLE:
                    begin
                        // front panel is always armed; remote waits for initiate
                        if (cmd_init || !remote)
                        begin
                            trigger_ready_indicator_left <= trigger_ready_indicator_total;
                            state     <= S_WAIT;
                        end
                    end
                    S_WAIT:
                    begin
                        if (fire)
                        begin
                            samp_left  <= samples;
                            delay_left <= eff_delay;
                            tick_cnt   <= 5'h00;
                            state      <= S_DELAY;
                        end
                    end
                    S_DELAY:
                    begin
                        if (delay_left == 32'h00000000)
                            state <= S_START;
                        else if (tick)
                            delay_left <= delay_left - 32'h00000001;
                    end
                    S_START:
                    begin
                        MEAS_START_OUT <= 1'b1;
                        state          <= S_BUSY;
                    end
                    S_BUSY:
                    begin
                        if (MEAS_DONE_IN)
                        begin
                            if (samp_left > 16'h0001)
                            begin
                                samp_left <= samp_left - 16'h0001;
                                state     <= S_START;
                            end
                            else if (trigger_ready_indicator_left > 16'h0001)
                            begin
                                trigger_ready_indicator_left <= trigger_ready_indicator_left - 16'h0001;
                                state     <= S_WAIT;
                            end
                            else
                            begin
                                trigger_ready_indicator_left <= 16'h0000;
                                state     <= S_IDLE;
                            end
                        end
                    end
                    default:
                        state <= S_IDLE;
                endcase
            end
        end
    end

    // indicators and complete pulse
    always @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            comp_cnt                         <= 6'h00;
            MEASUREMENT_COMPLETE_PULSE_N_OUT <= 1'b1;
            TRIGGER_READY_INDICATOR_OUT      <= 1'b0;
            EXTERNAL_SOURCE_INDICATOR_OUT    <= 1'b0;
            SAMPLING_OUT                     <= 1'b0;
        end
        else
        begin
            TRIGGER_READY_INDICATOR_OUT   <= (state == S_WAIT) && (src == `MTS_SRC_SINGLE);
            EXTERNAL_SOURCE_INDICATOR_OUT <= (src == `MTS_SRC_EXT);
            SAMPLING_OUT                  <= (state == S_START) || (state == S_BUSY);
            // fixed-width low pulse so slow ttl switch gear sees it
            if (state == S_BUSY && MEAS_DONE_IN)
            begin
                comp_cnt                         <= COMP_LAST;
                MEASUREMENT_COMPLETE_PULSE_N_OUT <= 1'b0;
            end
            else if (comp_cnt != 6'h00)
                comp_cnt <= comp_cnt - 6'h01;
            else
                MEASUREMENT_COMPLETE_PULSE_N_OUT <= 1'b1;
        end
    end

    // reading hold: two in-band steps means three stable readings
    always @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            last_reading <= 32'h00000000;
            have_last    <= 1'b0;
            stable_cnt   <= 2'h0;
            held         <= 32'h00000000;
            frozen       <= 1'b0;
            BEEP_OUT     <= 1'b0;
        end
        else
        begin
            BEEP_OUT <= 1'b0;
            if (!ctrl[`MTS_CTRL_HOLD])
                frozen <= 1'b0;
            if (state == S_BUSY && MEAS_DONE_IN)
            begin
                last_reading <= READING_IN;
                have_last    <= 1'b1;
                if (!in_band)
                    stable_cnt <= 2'h0;
                else if (stable_cnt != 2'h2)
                    stable_cnt <= stable_cnt + 2'h1;
                if (in_band && stable_cnt != 2'h0 && ctrl[`MTS_CTRL_HOLD] && !frozen)
                begin
                    held     <= READING_IN;
                    frozen   <= 1'b1;
                    BEEP_OUT <= 1'b1;
                end
            end
        end
    end

endmodule // mtseq_top

// >>> tb/mtseq_chk.sv
// port assertions for the trigger sequencer
`timescale 1ns/1ps
module mtseq_chk (
    input wire        MCLK_IN,
    input wire        RST_N_IN,
    input wire        AXI_AWVALID_IN,
    input wire        AXI_AWREADY_OUT,
    input wire        AXI_BVALID_OUT,
    input wire        AXI_BREADY_IN,
    input wire [1:0]  AXI_BRESP_OUT,
    input wire        AXI_ARVALID_IN,
    input wire        AXI_ARREADY_OUT,
    input wire        AXI_RVALID_OUT,
    input wire        AXI_RREADY_IN,
    input wire [31:0] AXI_RDATA_OUT,
    input wire        MEASUREMENT_COMPLETE_PULSE_N_OUT,
    input wire        TRIGGER_READY_INDICATOR_OUT,
    input wire        SAMPLING_OUT,
    input wire        MEAS_START_OUT,
    input wire        MEAS_DONE_IN,
    input wire        BEEP_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    AST_START_ONE: assert property (MEAS_START_OUT |=> !MEAS_START_OUT)
        else $error("start pulse too long");
    AST_START_SAMP: assert property (MEAS_START_OUT |-> SAMPLING_OUT)
        else $error("start outside sampling");
    AST_COMP_LOW: assert property (MEAS_DONE_IN && SAMPLING_OUT
        |=> !MEASUREMENT_COMPLETE_PULSE_N_OUT [*8]) else $error("complete pulse missing");
    AST_COMP_CAUSE: assert property ($fell(MEASUREMENT_COMPLETE_PULSE_N_OUT)
        |-> $past(MEAS_DONE_IN)) else $error("complete pulse without reading");
    AST_RDY_IDLE: assert property (TRIGGER_READY_INDICATOR_OUT |-> !SAMPLING_OUT)
        else $error("ready while sampling");
    AST_BEEP_ONE: assert property (BEEP_OUT |=> !BEEP_OUT)
        else $error("beep too long");
    AST_AW_B: assert property (AXI_AWVALID_IN && AXI_AWREADY_OUT |=> AXI_BVALID_OUT)
        else $error("no write response");
    AST_B_HOLD: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN
        |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT)) else $error("write response dropped");
    AST_AR_R: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT)
        else $error("no read response");
    AST_R_HOLD: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN
        |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT)) else $error("read data dropped");
endmodule // mtseq_chk

bind mtseq_top mtseq_chk i_chk (.*);

// >>> tb/mtseq_fe.sv
// front-end model answering each reading request
`timescale 1ns/1ps
module mtseq_fe (
    input  wire        clk_in,
    input  wire        start_in,
    input  wire [31:0] value_in,
    output reg         done_out = 1'b0,
    output reg  [31:0] reading_out = 32'h00000000
);
    reg [3:0] wait_cnt = 4'h0;
    reg       slow = 1'b0;
    always @(posedge clk_in)
    begin
        done_out <= 1'b0;
        // stale data must not look valid
        reading_out <= ~reading_out;
        if (start_in)
        begin
            wait_cnt <= slow ? 4'h7 : 4'h1;
            slow <= ~slow;
        end
        else if (wait_cnt != 4'h0)
        begin
            wait_cnt <= wait_cnt - 4'h1;
            if (wait_cnt == 4'h1)
            begin
                done_out <= 1'b1;
                reading_out <= value_in;
            end
        end
    end
endmodule // mtseq_fe

// >>> tb/measurement_trigger_sequencer_tb.sv
// self-checking bench for the trigger sequencer
`timescale 1ns/1ps
`include "mtseq_consts.vh"
module measurement_trigger_sequencer_tb;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         awv = 1'b0;
    reg         wv = 1'b0;
    reg         bry = 1'b0;
    reg         arv = 1'b0;
    reg         rry = 1'b0;
    reg         key = 1'b0;
    reg         external_source_indicator = 1'b1;
    reg         cmp_q = 1'b1;
    reg  [7:0]  awa = 8'h00;
    reg  [7:0]  ara = 8'h00;
    reg  [31:0] wd = 32'h00000000;
    reg  [31:0] val = 32'h00001234;
    reg  [31:0] rdv;
    reg  [1:0]  rsp;
    wire        awr, wrdy, bv, arr, rv, cmp_n, trdy, exti, samp, mst, mdn, beep;
    wire [1:0]  br, rr;
    wire [31:0] rdat, rdg;
    integer     mismatches = 0;
    integer     checks_done = 0;
    integer     n_st = 0;
    integer     n_cmp = 0;
    integer     n_bp = 0;
    integer     cyc = 0;
    integer     t_st = 0;
    integer     s;
    always #25 clk = ~clk;
    mtseq_top i_dut (.MCLK_IN(clk), .RST_N_IN(rst_n),
        .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_AWADDR_IN(awa),
        .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wrdy), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hF),
        .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(bry), .AXI_BRESP_OUT(br),
        .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr), .AXI_ARADDR_IN(ara),
        .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rry), .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rr),
        .SINGLE_KEY_IN(key), .EXTERNAL_TRIGGER_INPUT_IN(external_source_indicator),
        .MEASUREMENT_COMPLETE_PULSE_N_OUT(cmp_n), .TRIGGER_READY_INDICATOR_OUT(trdy),
        .EXTERNAL_SOURCE_INDICATOR_OUT(exti), .SAMPLING_OUT(samp), .MEAS_START_OUT(mst),
        .MEAS_DONE_IN(mdn), .READING_IN(rdg), .BEEP_OUT(beep));
    mtseq_fe i_fe (.clk_in(clk), .start_in(mst), .value_in(val), .done_out(mdn),
        .reading_out(rdg));
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        cmp_q <= cmp_n;
        if (cmp_q && !cmp_n)
            n_cmp <= n_cmp + 1;
        if (beep)
            n_bp <= n_bp + 1;
        if (mst)
        begin
            n_st <= n_st + 1;
            t_st <= cyc;
        end
    end
    task chk(input [31:0] seen, input [31:0] want);
    begin
        checks_done = checks_done + 1;
        if (seen !== want)
        begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    end
    endtask
    task test_done;
    begin
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // ready is combinational, so it is judged at the negedge before the taking edge
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        @(negedge clk);
        while (!awr) @(negedge clk);
        @(posedge clk);
        awv <= 1'b0;
        wv <= 1'b0;
        @(negedge clk);
        while (!bv) @(negedge clk);
        rsp = br;
        @(posedge clk);
        bry <= 1'b0;
    end
    endtask
    task rd(input [7:0] a);
    begin
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        @(negedge clk);
        while (!arr) @(negedge clk);
        @(posedge clk);
        arv <= 1'b0;
        @(negedge clk);
        while (!rv) @(negedge clk);
        rdv = rdat;
        rsp = rr;
        @(posedge clk);
        rry <= 1'b0;
    end
    endtask
    task press;
    begin
        @(posedge clk);
        key <= 1'b1;
        repeat (3) @(posedge clk);
        key <= 1'b0;
    end
    endtask
    task t_regs;
    begin
        rd(`MTS_OFF_CTRL);
        chk(rdv, 32'h00000020);
        rd(`MTS_OFF_TRIGS);
        chk(rdv, 32'h00000001);
        rd(`MTS_OFF_DELAY);
        chk(rdv, 32'h00000000);
        rd(8'h40);
        chk({30'h0, rsp}, {30'h0, `MTS_RESP_SLVERR});
        wr(8'h44, 32'h00000001);
        chk({30'h0, rsp}, {30'h0, `MTS_RESP_SLVERR});
        wr(`MTS_OFF_SAMPLES, 32'h0000EA60);
        rd(`MTS_OFF_SAMPLES);
        chk(rdv, 32'h0000C350);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`MTS_OFF_SAMPLES);
        chk(rdv, 32'h00000001);
        wr(`MTS_OFF_SAMPLES, 32'h00000000);
        rd(`MTS_OFF_SAMPLES);
        chk(rdv, 32'h00000001);
    end
    endtask
    task t_auto;
    begin
        wr(`MTS_OFF_CTRL, 32'h00000000);
        wr(`MTS_OFF_CMD, 32'h00000004);
        repeat (40) @(posedge clk);
        s = n_st;
        repeat (200) @(posedge clk);
        chk({31'h0, n_st - s >= 8}, 32'h1);
        chk({31'h0, n_cmp > 0}, 32'h1);
    end
    endtask
    task t_single;
    begin
        wr(`MTS_OFF_CTRL, 32'h00000002);
        wr(`MTS_OFF_SAMPLES, 32'h00000002);
        repeat (40) @(posedge clk);
        s = n_st;
        chk({31'h0, trdy}, 32'h1);
        repeat (50) @(posedge clk);
        chk(n_st - s, 0);
        press;
        repeat (100) @(posedge clk);
        chk(n_st - s, 2);
        chk({31'h0, trdy}, 32'h1);
    end
    endtask
    task t_hold;
    begin
        wr(`MTS_OFF_BAND, 32'h00000004);
        wr(`MTS_OFF_SAMPLES, 32'h00000003);
        wr(`MTS_OFF_CTRL, 32'h00000012);
        repeat (40) @(posedge clk);
        s = n_bp;
        press;
        repeat (150) @(posedge clk);
        chk(n_bp - s, 1);
        rd(`MTS_OFF_HELD);
        chk(rdv, val);
    end
    endtask
    task t_ext;
    begin
        wr(`MTS_OFF_SAMPLES, 32'h00000002);
        wr(`MTS_OFF_CTRL, 32'h00000003);
        repeat (40) @(posedge clk);
        chk({31'h0, exti}, 32'h1);
        s = n_st;
        external_source_indicator <= 1'b0;
        repeat (3) @(posedge clk);
        external_source_indicator <= 1'b1;
        repeat (100) @(posedge clk);
        chk(n_st - s, 2);
    end
    endtask
    task t_remote;
    begin
        wr(`MTS_OFF_TRIGS, 32'h00000002);
        wr(`MTS_OFF_CTRL, 32'h0000000C);
        repeat (40) @(posedge clk);
        chk({31'h0, exti}, 32'h0);
        wr(`MTS_OFF_CMD, 32'h00000004);
        s = n_st;
        wr(`MTS_OFF_CMD, 32'h00000001);
        repeat (50) @(posedge clk);
        chk(n_st - s, 0);
        repeat (2)
        begin
            wr(`MTS_OFF_CMD, 32'h00000002);
            repeat (60) @(posedge clk);
        end
        chk(n_st - s, 4);
        rd(`MTS_OFF_STATUS);
        chk({29'h0, rdv[2:0]}, 32'h0);
        wr(`MTS_OFF_CMD, 32'h00000002);
        repeat (60) @(posedge clk);
        chk(n_st - s, 4);
        wr(`MTS_OFF_CTRL, 32'h00000008);
        wr(`MTS_OFF_CMD, 32'h00000001);
        repeat (200) @(posedge clk);
        chk(n_st - s, 8);
    end
    endtask
    task timed(input integer lo);
        integer k;
    begin
        repeat (40) @(posedge clk);
        s = n_st;
        k = cyc;
        press;
        repeat (lo + 100) @(posedge clk);
        chk(n_st - s, 1);
        chk({31'h0, t_st - k >= lo && t_st - k <= lo + 40}, 32'h1);
    end
    endtask
    task t_delay;
    begin
        wr(`MTS_OFF_SAMPLES, 32'h00000001);
        wr(`MTS_OFF_DELAY, 32'h00000005);
        wr(`MTS_OFF_CTRL, 32'h00000002);
        timed(100);
        wr(`MTS_OFF_DELAY, 32'h00000000);
        wr(`MTS_OFF_MEASCFG, 32'h00000004);
        wr(`MTS_OFF_CTRL, 32'h00000022);
        timed(30000);
        wr(`MTS_OFF_MEASCFG, 32'h00000000);
        timed(20000);
    end
    endtask
    initial
    begin
        repeat (90000) @(posedge clk);
        mismatches = mismatches + 1;
        test_done;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_auto;
        t_single;
        t_hold;
        t_ext;
        t_remote;
        t_delay;
        test_done;
    end
endmodule // measurement_trigger_sequencer_tb
